/* File: common/adc_out_pkg.sv */
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package adc_out_pkg;

    // word and buffer geometry
    localparam int WORD_W     = 8;
    localparam int FIFO_DEPTH = 4;

    // timing counts in input clock falling edges
    localparam logic [7:0]  CAL_REQ_TICKS   = 8'h50;
    localparam logic [15:0] POWERON_DLY     = 16'h0400;
    localparam logic [15:0] CAL_RUN_LEN     = 16'h0800;

    // synchronised pin vector positions and reset value
    localparam int PIN_SCLK  = 0;
    localparam int PIN_DOWN  = 1;
    localparam int PIN_EDGE  = 2;
    localparam int PIN_SWING = 3;
    localparam int PIN_DDR   = 4;
    localparam int PIN_CAL   = 5;
    localparam int PIN_N     = 6;
    localparam logic [5:0] PIN_SYNC_RST = 6'h02;

    // calibration sequencer states
    typedef enum logic [1:0] {
        CAL_HOLD,
        CAL_DELAY,
        CAL_RUN,
        CAL_IDLE
    } cal_state_t;

    // one even/odd pair of output words
    typedef struct packed {
        logic [WORD_W-1:0] even;
        logic [WORD_W-1:0] odd;
    } pair_t;

endpackage : adc_out_pkg

/* File: hw/adc_output_demux_powerdown_ctrl.sv */
//------------------------------------------------------------------------
// pair buffer
//------------------------------------------------------------------------
module adc_pair_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic        full;
    logic        empty;

    // flags from pointer distance
    assign empty     = (s.wr == s.rd);
    assign full      = (s.wr[AW-1:0] == s.rd[AW-1:0]) && (s.wr[AW] != s.rd[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = s.mem[s.rd[AW-1:0]];

    // pointer and storage update
    always_comb begin
        next_s = s;
        if (in_valid && !full) begin
            next_s.mem[s.wr[AW-1:0]] = in_data;
            next_s.wr = s.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            next_s.rd = s.rd + 1'b1;
        end
        if (flush) begin
            next_s.rd = next_s.wr;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

endmodule : adc_pair_fifo

//------------------------------------------------------------------------
// output demux, latch clock and power-down control
//------------------------------------------------------------------------
module adc_output_demux_powerdown_ctrl #(
    parameter logic [15:0] POWERON_TICKS = adc_out_pkg::POWERON_DLY,
    parameter logic [15:0] CAL_TICKS     = adc_out_pkg::CAL_RUN_LEN,
    parameter int          DEPTH         = adc_out_pkg::FIFO_DEPTH
) (
    // clock, reset, enable
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    // pins from outside
    input  wire logic       sample_clk,
    input  wire logic       power_down_input,
    input  wire logic       output_edge_select,
    input  wire logic       output_swing_select,
    input  wire logic       ddr_select,
    input  wire logic       cal_request,
    // conversion result from the core, signed
    input  wire logic [7:0] conv_data,
    output logic            conv_ready,
    // output buses
    output logic [7:0]      bus_even_p,
    output logic [7:0]      bus_even_n,
    output logic [7:0]      bus_odd_p,
    output logic [7:0]      bus_odd_n,
    output logic            data_oe,
    // latch clock pair
    output logic            output_latch_clock_p,
    output logic            output_latch_clock_n,
    // status and analog controls
    output logic            calibration_active,
    output logic            strong_drive,
    output logic            analog_enable
);
    typedef struct packed {
        logic [adc_out_pkg::PIN_N-1:0] sync1;
        logic [adc_out_pkg::PIN_N-1:0] sync2;
        logic                          sclk_d;
        adc_out_pkg::cal_state_t       cal;
        logic [15:0]                   cnt;
        logic [7:0]                    low_cnt;
        logic [7:0]                    high_cnt;
        logic                          clock_seen;
        logic                          odd_phase;
        logic [7:0]                    even_word;
        logic                          lclk;
        logic                          ddr_div;
        logic                          down_active;
        adc_out_pkg::pair_t            bus;
    } state_t;

    state_t             s;
    state_t             next_s;
    logic               tick;
    logic               down_s;
    logic               edge_s;
    logic               ddr_s;
    logic               cal_s;
    logic [7:0]         code;
    logic               push;
    logic               toggle;
    logic               change;
    logic               pop_valid;
    adc_out_pkg::pair_t pop_data;

    // synchronised pin views and falling edge of the input clock
    assign tick   = s.sclk_d && !s.sync2[adc_out_pkg::PIN_SCLK];
    assign down_s = s.sync2[adc_out_pkg::PIN_DOWN];
    assign edge_s = s.sync2[adc_out_pkg::PIN_EDGE];
    assign ddr_s  = s.sync2[adc_out_pkg::PIN_DDR];
    assign cal_s  = s.sync2[adc_out_pkg::PIN_CAL];

    // offset binary from two's complement core result
    assign code = {~conv_data[7], conv_data[6:0]};

    // pair is complete on the odd edge
    assign push = tick && s.odd_phase && !s.down_active;

    // latch clock halts during calibration and power down
    assign toggle = tick && (s.cal != adc_out_pkg::CAL_RUN) && !s.down_active
                    && (!ddr_s || s.ddr_div);
    // data moves on every edge in ddr, chosen edge otherwise
    assign change = toggle && (ddr_s || (!s.lclk == edge_s));

    adc_pair_fifo #(
        .WIDTH ($bits(adc_out_pkg::pair_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .flush     (s.down_active),
        .in_valid  (push),
        .in_ready  (conv_ready),
        .in_data   ({s.even_word, code}),
        .out_valid (pop_valid),
        .out_ready (change),
        .out_data  (pop_data)
    );

    // sequencing of sync, calibration and output words
    always_comb begin
        next_s = s;
        next_s.sync1  = {cal_request, ddr_select, output_swing_select,
                         output_edge_select, power_down_input, sample_clk};
        next_s.sync2  = s.sync1;
        next_s.sclk_d = s.sync2[adc_out_pkg::PIN_SCLK];
        if (tick) begin
            next_s.clock_seen = 1'b1;
        end
        // even/odd alternation of conversions
        if (tick && !s.down_active) begin
            next_s.odd_phase = !s.odd_phase;
            if (!s.odd_phase) begin
                next_s.even_word = code;
            end
        end
        if (toggle) begin
            next_s.lclk    = !s.lclk;
            next_s.ddr_div = 1'b0;
        end else if (tick && ddr_s) begin
            next_s.ddr_div = 1'b1;
        end
        if (change && pop_valid) begin
            next_s.bus = pop_data;
        end
        // power down waits for a running calibration
        next_s.down_active = down_s
                             && (s.cal != adc_out_pkg::CAL_RUN);
        if (s.down_active) begin
            next_s.odd_phase = 1'b0;
        end
        // calibration sequencer
        case (s.cal)
            adc_out_pkg::CAL_HOLD: begin
                if (!down_s) begin
                    next_s.cal = adc_out_pkg::CAL_DELAY;
                    next_s.cnt = '0;
                end
            end
            adc_out_pkg::CAL_DELAY: begin
                if (down_s) begin
                    next_s.cal = adc_out_pkg::CAL_HOLD;
                end else if (tick) begin
                    next_s.cnt = s.cnt + 16'h0001;
                    if (s.cnt + 16'h0001 >= POWERON_TICKS) begin
                        next_s.cal = adc_out_pkg::CAL_RUN;
                        next_s.cnt = '0;
                    end
                end
            end
            adc_out_pkg::CAL_RUN: begin
                if (tick) begin
                    next_s.cnt = s.cnt + 16'h0001;
                    if (s.cnt + 16'h0001 >= CAL_TICKS) begin
                        next_s.cal = adc_out_pkg::CAL_IDLE;
                        next_s.cnt = '0;
                    end
                end
            end
            adc_out_pkg::CAL_IDLE: begin
                if (s.down_active || down_s) begin
                    next_s.low_cnt  = '0;
                    next_s.high_cnt = '0;
                end else if (tick && !cal_s) begin
                    next_s.high_cnt = '0;
                    if (s.low_cnt < adc_out_pkg::CAL_REQ_TICKS) begin
                        next_s.low_cnt = s.low_cnt + 8'h01;
                    end
                end else if (tick && s.low_cnt >= adc_out_pkg::CAL_REQ_TICKS)
                begin
                    next_s.high_cnt = s.high_cnt + 8'h01;
                    if (s.high_cnt + 8'h01 >= adc_out_pkg::CAL_REQ_TICKS) begin
                        next_s.cal      = adc_out_pkg::CAL_RUN;
                        next_s.low_cnt  = '0;
                        next_s.high_cnt = '0;
                        next_s.cnt      = '0;
                    end
                end
            end
            default: begin
                next_s.cal = adc_out_pkg::CAL_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s             <= '0;
            s.sync1       <= adc_out_pkg::PIN_SYNC_RST;
            s.sync2       <= adc_out_pkg::PIN_SYNC_RST;
            s.cal         <= adc_out_pkg::CAL_HOLD;
            s.down_active <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // pin drivers
    assign bus_even_p           = s.bus.even;
    assign bus_even_n           = ~s.bus.even;
    assign bus_odd_p            = s.bus.odd;
    assign bus_odd_n            = ~s.bus.odd;
    assign data_oe              = !s.down_active;
    assign output_latch_clock_p = s.lclk;
    assign output_latch_clock_n = !s.lclk;
    assign calibration_active   = (s.cal == adc_out_pkg::CAL_RUN);
    assign strong_drive         = s.sync2[adc_out_pkg::PIN_SWING];
    assign analog_enable        = s.clock_seen && !s.down_active;

    //--------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------
    sequence seq_toggle_ddr;
        ce && toggle && ddr_s;
    endsequence

    sequence seq_tick_held;
        tick && s.ddr_div;
    endsequence

    a_edge_choice: assert property (@(posedge clk_sys) disable iff (rst)
        ce && change && !ddr_s |=> s.lclk == $past(edge_s))
        else $error("data changed on the wrong latch clock edge");

    a_single_rate: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(ddr_s) && $changed(s.bus)
        |-> $changed(s.lclk) && s.lclk == $past(edge_s))
        else $error("single rate data moved on the unselected edge");

    a_down_hiz: assert property (@(posedge clk_sys) disable iff (rst)
        ce && down_s && !calibration_active |=> !data_oe)
        else $error("data pins driven while powered down");

    a_cal_defer: assert property (@(posedge clk_sys) disable iff (rst)
        calibration_active |-> data_oe)
        else $error("power down entered during calibration");

    a_boot_hold: assert property (@(posedge clk_sys) disable iff (rst)
        ce && s.cal == adc_out_pkg::CAL_HOLD && down_s |=> !calibration_active)
        else $error("power-on calibration began under power down");

    a_req_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        ce && s.down_active && s.cal == adc_out_pkg::CAL_IDLE
        |=> !calibration_active && s.high_cnt == 8'h00)
        else $error("calibration request honoured while powered down");

    a_pair_route: assert property (@(posedge clk_sys) disable iff (rst)
        ce && tick && !s.down_active && !s.odd_phase
        |=> s.odd_phase && s.even_word == $past(code))
        else $error("even word not captured on an even edge");

    a_ddr_quarter: assert property (@(posedge clk_sys) disable iff (rst)
        seq_toggle_ddr |-> seq_tick_held)
        else $error("ddr latch clock toggled faster than quarter rate");

    a_offset_code: assert property (@(posedge clk_sys) disable iff (rst)
        push |-> code[6:0] == conv_data[6:0] && code[7] != conv_data[7])
        else $error("code not offset binary");

    a_clock_wait: assert property (@(posedge clk_sys) disable iff (rst)
        !s.clock_seen |-> !analog_enable)
        else $error("analog enabled before input clock ran");

    a_cal_lclk: assert property (@(posedge clk_sys) disable iff (rst)
        ce && calibration_active && $past(calibration_active)
        |-> $stable(s.lclk))
        else $error("latch clock toggled during calibration");

    a_bus_rate: assert property (@(posedge clk_sys) disable iff (rst)
        ce && change && pop_valid |=> !change && s.bus == $past(pop_data))
        else $error("bus word not taken from the pair buffer");

endmodule : adc_output_demux_powerdown_ctrl

/* File: tb/adc_rx_model.sv */
//------------------------------------------------------------------------
// receiving logic that latches the buses with the forwarded clock
//------------------------------------------------------------------------
module adc_rx_model #(
    parameter int DISCARD = 6
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // receiver set-up
    input  wire logic       edge_hi,
    input  wire logic       ddr,
    // pins from the device
    input  wire logic [7:0] bus_even_p,
    input  wire logic [7:0] bus_odd_p,
    input  wire logic       data_oe,
    input  wire logic       output_latch_clock_p,
    // rebuilt sample stream
    output logic            rx_valid,
    output logic [7:0]      rx_word,
    output logic [7:0]      half_word
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       lc_q;
    logic       odd_due;
    logic [7:0] odd_q;
    logic [3:0] skip;

    // capture on the edge away from the change edge in single rate, on every latch clock edge in ddr, emit even then odd word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lc_q      <= 1'b0;
            odd_due   <= 1'b0;
            odd_q     <= 8'h00;
            skip      <= 4'(DISCARD);
            rx_valid  <= 1'b0;
            rx_word   <= 8'h00;
            half_word <= 8'h00;
        end else begin
            lc_q     <= output_latch_clock_p;
            rx_valid <= 1'b0;
            odd_due  <= 1'b0;
            if (!data_oe) begin
                skip <= 4'(DISCARD);
            end else if (odd_due) begin
                rx_valid <= 1'b1;
                rx_word  <= odd_q;
            end else if (output_latch_clock_p != lc_q &&
                         (ddr || output_latch_clock_p != edge_hi)) begin
                if (skip != 4'h0) begin
                    skip <= skip - 4'h1;
                end else begin
                    rx_valid  <= 1'b1;
                    rx_word   <= bus_even_p;
                    odd_q     <= bus_odd_p;
                    odd_due   <= 1'b1;
                    half_word <= bus_even_p;
                end
            end
        end
    end
endmodule : adc_rx_model

/* File: tb/test_adc_output_demux_powerdown_ctrl.sv */
module test_adc_output_demux_powerdown_ctrl;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic       ddr;
        logic       edge_hi;
        logic       swing;
        logic [7:0] conv;
        logic [7:0] code;
    } row_t;

    logic       clk_sys, rst, ce, sample_clk, power_down_input;
    logic       output_edge_select, output_swing_select, ddr_select;
    logic       cal_request, conv_ready, data_oe, strong_drive;
    logic       output_latch_clock_p, output_latch_clock_n;
    logic       calibration_active, analog_enable, rx_valid;
    logic [7:0] conv_data, bus_even_p, bus_even_n, bus_odd_p, bus_odd_n;
    logic [7:0] rx_word, prev, be_q, half_word;
    logic [8:0] hold_q;
    logic       sc_run, counting, mon_on, sc_q, lc_q, gap_ok;
    logic       have_prev, cal_seen, cal_q;
    int         bad_count, checks_done, gap;
    row_t       rows [4] = '{
        '{1'b0, 1'b1, 1'b1, 8'h7f, 8'hff},
        '{1'b0, 1'b0, 1'b0, 8'h80, 8'h00},
        '{1'b1, 1'b1, 1'b0, 8'h00, 8'h80},
        '{1'b1, 1'b0, 1'b1, 8'hff, 8'h7f}
    };

    adc_output_demux_powerdown_ctrl #(
        .POWERON_TICKS(16'h0008),
        .CAL_TICKS    (16'h0010),
        .DEPTH        (4)
    ) uut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .sample_clk(sample_clk),
        .power_down_input(power_down_input),
        .output_edge_select(output_edge_select),
        .output_swing_select(output_swing_select),
        .ddr_select(ddr_select), .cal_request(cal_request),
        .conv_data(conv_data), .conv_ready(conv_ready),
        .bus_even_p(bus_even_p), .bus_even_n(bus_even_n),
        .bus_odd_p(bus_odd_p), .bus_odd_n(bus_odd_n), .data_oe(data_oe),
        .output_latch_clock_p(output_latch_clock_p),
        .output_latch_clock_n(output_latch_clock_n),
        .calibration_active(calibration_active),
        .strong_drive(strong_drive), .analog_enable(analog_enable)
    );

    adc_rx_model rx (
        .clk_sys(clk_sys), .rst(rst), .edge_hi(output_edge_select),
        .ddr(ddr_select), .bus_even_p(bus_even_p), .bus_odd_p(bus_odd_p),
        .data_oe(data_oe), .output_latch_clock_p(output_latch_clock_p),
        .rx_valid(rx_valid), .rx_word(rx_word), .half_word(half_word)
    );

    //--------------------------------------------------------------------
    // clocks and stimulus helpers
    //--------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // sample clock, unrelated phase, held until started
    initial begin
        sample_clk = 1'b0;
        #3;
        forever begin
            #80;
            if (sc_run) sample_clk = ~sample_clk;
        end
    end

    // counting core result, one step per sample tick
    always @(negedge clk_sys) begin
        sc_q <= sample_clk;
        if (counting && sc_q && !sample_clk) conv_data <= conv_data + 8'h01;
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n * 8) @(negedge clk_sys);
    endtask : ticks

    task automatic wait_cal(input logic lvl, input int lim);
        int n;
        n = 0;
        while (calibration_active !== lvl && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        check("cal wait", calibration_active, lvl);
    endtask : wait_cal

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic check_reset();
        check("reset ctl", {data_oe, calibration_active, analog_enable,
              strong_drive, output_latch_clock_p, output_latch_clock_n,
              conv_ready, 1'b0, bus_even_p}, 16'h0600);
        check("reset bus", {bus_odd_p, bus_even_n}, 16'h00ff);
    endtask : check_reset

    //--------------------------------------------------------------------
    // latch clock, data edge and stream monitors
    //--------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (calibration_active === 1'b1) cal_seen <= 1'b1;
        if (calibration_active && cal_q && output_latch_clock_p != lc_q)
            check("cal clock", 1'b1, 1'b0);
        cal_q <= calibration_active;
        if (mon_on) begin
            if (output_latch_clock_p != lc_q) begin
                if (gap_ok) check("gap", gap, ddr_select ? 16 : 8);
                gap    <= 1;
                gap_ok <= 1'b1;
            end else begin
                gap <= gap + 1;
            end
            if (bus_even_p != be_q)
                check("data edge", {output_latch_clock_p != lc_q, ddr_select
                      | (output_latch_clock_p == output_edge_select)},
                      2'b11);
            if (rx_valid && have_prev)
                check("rx word", rx_word, 8'(prev + 8'h01));
            if (rx_valid) prev <= rx_word;
            if (rx_valid) have_prev <= 1'b1;
        end else begin
            gap_ok    <= 1'b0;
            have_prev <= 1'b0;
        end
        lc_q <= output_latch_clock_p;
        be_q <= bus_even_p;
    end

    initial begin
        #400000;
        bad_count++;
        finish_test();
    end

    //--------------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------------
    initial begin
        rst = 1'b1; ce = 1'b1; power_down_input = 1'b0; cal_request = 1'b0;
        output_edge_select = 1'b1; output_swing_select = 1'b0;
        ddr_select = 1'b0; conv_data = 8'h00; sc_run = 1'b0;
        counting = 1'b0; mon_on = 1'b0; cal_seen = 1'b0;
        bad_count = 0; checks_done = 0;
        repeat (5) @(negedge clk_sys);
        check_reset();
        rst = 1'b0;
        // no sample clock yet, then powered down at start-up
        ticks(6);
        check("analog", analog_enable, 1'b0);
        power_down_input = 1'b1;
        sc_run = 1'b1;
        ticks(30);
        check("down hold", {calibration_active, data_oe}, 2'b00);
        power_down_input = 1'b0;
        wait_cal(1'b1, 320);
        gap = 0;
        while (calibration_active === 1'b1 && gap < 400) begin
            @(negedge clk_sys);
            gap++;
        end
        check("cal length", gap, 16 * 8);
        ticks(4);
        check("running", {data_oe, analog_enable}, 2'b11);
        // output modes, stream then a fixed code
        foreach (rows[i]) begin
            ddr_select = rows[i].ddr;
            output_edge_select = rows[i].edge_hi;
            output_swing_select = rows[i].swing;
            counting = 1'b1;
            ticks(12);
            mon_on = 1'b1;
            ticks(24);
            mon_on = 1'b0;
            counting = 1'b0;
            @(negedge clk_sys);
            conv_data = rows[i].conv;
            ticks(24);
            check("codes", {bus_even_p, bus_odd_p}, {2{rows[i].code}});
            check("compl", {bus_even_n, bus_odd_n}, ~{2{rows[i].code}});
            check("drive", strong_drive, rows[i].swing);
            check("half", half_word, rows[i].code);
        end
        // manual request while powered down is ignored
        counting = 1'b1;
        power_down_input = 1'b1;
        ticks(4);
        check("down oe", data_oe, 1'b0);
        cal_seen = 1'b0;
        ticks(90);
        cal_request = 1'b1;
        ticks(90);
        power_down_input = 1'b0;
        ticks(100);
        check("down request", cal_seen, 1'b0);
        // manual calibration, buffer fills, power down deferred
        cal_request = 1'b0;
        ticks(85);
        cal_request = 1'b1;
        ticks(70);
        check("cal early", cal_seen, 1'b0);
        wait_cal(1'b1, 200);
        ticks(9);
        check("full", conv_ready, 1'b0);
        power_down_input = 1'b1;
        ticks(3);
        check("deferred", data_oe, 1'b1);
        wait_cal(1'b0, 160);
        ticks(2);
        check("down late", {data_oe, conv_ready}, 2'b01);
        power_down_input = 1'b0;
        ticks(16);
        mon_on = 1'b1;
        ticks(20);
        mon_on = 1'b0;
        check("resumed", have_prev, 1'b1);
        // clock enable low freezes latch clock and buses
        hold_q = {output_latch_clock_p, bus_even_p};
        ce = 1'b0;
        ticks(4);
        check("frozen", {output_latch_clock_p, bus_even_p}, hold_q);
        ce = 1'b1;
        // second reset in mid-run, power down already high
        power_down_input = 1'b1;
        rst = 1'b1;
        ticks(1);
        check_reset();
        rst = 1'b0;
        ticks(20);
        check("boot hold", calibration_active, 1'b0);
        power_down_input = 1'b0;
        wait_cal(1'b1, 320);
        finish_test();
    end
endmodule : test_adc_output_demux_powerdown_ctrl
